// *** lamp_fault_startup_sequencer.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "lamp_seq_defs.svh"

// Operation
// - Chip enable low stops high-side drive at once; low sides run until supply decays.
// - Chip enable low puts regulator base drive in high impedance.
// - Switching stays off until supply good and reference valid are both true.
// - Once running, switching continues until supply drops below turn-off level.
// - No faults during start-up; overvoltage only steers frequency.
// - Current detect above threshold means struck; start-up phase ends.
// - In steady state any enabled fault sets a latch holding switching off.
// - Fault latch clears only by power-on reset or chip enable toggle.
// - High overvoltage checked always after start-up, never blanked.
// - Low overvoltage fault, ignored while blanking ramp is below threshold.
// - Undercurrent fault when no current crossing in 8 clocks, blanked too.
// - Undercurrent counter runs on switching clock at twice drive frequency.
// - Start-up flag high in the off and start-up states only; selects thousandfold smaller ramp current.
// - Switching enable high lets switching run; low stops all switching except the low sides while chip enable is low.
// - Burst gating halts switching once per dimming cycle.
// - Start-up selects small ramp current and grounds auxiliary capacitor.
// - After start-up, large ramp current and auxiliary capacitor open.
// - Each new dimming cycle discharges the blanking ramp then releases it.
// - Soft-start ramp sinks before each cycle, sources once it starts.
// - In start-up, high overvoltage holds soft-start ramp at ground.
// - Battery sense gates only high-side driver, with hysteresis.
// - No strike before start-up interval ends shuts the circuit down.
// - After strike, full brightness for two dimming cycles before burst control.
module lamp_fault_startup_sequencer #(
  parameter int UC_CYCLES   = `UC_CYCLES,
  parameter int FULL_CYCLES = `FULL_BRIGHT_CYCLES
) (
  input  wire  logic        core_clk,
  input  wire  logic        reset_n,
  input  wire  logic        chip_enable_in,
  input  wire  logic        supply_good,
  input  wire  logic        supply_above_off_in,
  input  wire  logic        reference_valid_in,
  input  wire  logic        lamp_overvoltage_high_in,
  input  wire  logic        lamp_overvoltage_low_in,
  input  wire  logic        lamp_current_detect_in,
  input  wire  logic        blanking_ramp_above_in,
  input  wire  logic        battery_sense_in,
  input  wire  logic        battery_sense_high_in,
  input  wire  logic        dimming_on_in,
  input  wire  logic        drive_phase_in,
  input  wire  logic        high_side_pwm_in,
  input  wire  logic [3:0]  avs_address,
  input  wire  logic        avs_read,
  input  wire  logic        avs_write,
  input  wire  logic [31:0] avs_writedata,
  output logic [31:0]       avs_readdata,
  output logic              avs_waitrequest,
  output logic              switching_enable,
  output logic              burst_gating,
  output logic              startup_phase,
  output logic              blanking_ramp_discharge,
  output logic              blanking_ramp_low_current,
  output logic              aux_blanking_cap_switch,
  output logic              soft_start_ramp_source,
  output logic              soft_start_ramp_hold,
  output logic              high_side_gate_drive,
  output logic              low_side_drive_a,
  output logic              low_side_drive_b,
  output logic              regulator_base_drive_out,
  output logic              regulator_base_drive_oe,
  output logic              fault_latched
);

  if (UC_CYCLES < 2 || UC_CYCLES > 255) begin : g_bad_uc
    $error("UC_CYCLES out of range");
  end
  if (FULL_CYCLES < 1 || FULL_CYCLES > 15) begin : g_bad_full
    $error("FULL_CYCLES out of range");
  end

  // ****************************************************************
  // Input synchronisers
  // ****************************************************************
  localparam int NSYNC = 11;
  logic [NSYNC-1:0] sync1_reg;
  logic [NSYNC-1:0] sync2_reg;
  wire  [NSYNC-1:0] raw_in = {chip_enable_in, supply_good, supply_above_off_in,
                              reference_valid_in, lamp_overvoltage_high_in,
                              lamp_overvoltage_low_in, lamp_current_detect_in,
                              blanking_ramp_above_in, battery_sense_in,
                              battery_sense_high_in, dimming_on_in};

  genvar gi;
  generate
    for (gi = 0; gi < NSYNC; gi++) begin : g_sync
      always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
          sync1_reg[gi] <= 1'b0;
          sync2_reg[gi] <= 1'b0;
        end else begin
          sync1_reg[gi] <= raw_in[gi];
          sync2_reg[gi] <= sync1_reg[gi];
        end
      end
    end
  endgenerate

  wire ce_s      = sync2_reg[10];
  wire vgood_s   = sync2_reg[9];
  wire vabove_s  = sync2_reg[8];
  wire ref_s     = sync2_reg[7];
  wire ovh_s     = sync2_reg[6];
  wire ovl_s     = sync2_reg[5];
  wire cur_s     = sync2_reg[4];
  wire blank_s   = sync2_reg[3];
  wire batlo_s   = sync2_reg[2];
  wire bathi_s   = sync2_reg[1];
  wire dim_s     = sync2_reg[0];

  // ****************************************************************
  // Registers and edge detection
  // ****************************************************************
  logic [31:0]              ctrl_reg;
  logic                     ce_d_reg;
  logic                     dim_d_reg;
  logic                     run_reg;
  logic                     rd_ack_reg;
  logic                     hs_en_reg;
  logic [3:0]               fault_reg;
  logic [7:0]               uc_cnt_reg;
  logic [3:0]               full_cnt_reg;
  lamp_seq_pkg::seq_state_t state_reg;
  lamp_seq_pkg::seq_state_t state_next;

  wire ce_eff  = ce_s & ctrl_reg[`CTRL_CE_BIT];
  wire ce_rise = ce_eff & ~ce_d_reg;
  wire ce_fall = ~ce_eff & ce_d_reg;
  wire dim_start = dim_s & ~dim_d_reg;
  wire dim_end   = ~dim_s & dim_d_reg;
  wire steady    = (state_reg == lamp_seq_pkg::ST_FULL) ||
                   (state_reg == lamp_seq_pkg::ST_RUN);
  wire any_fault = |fault_reg[2:0];

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      ce_d_reg  <= 1'b0;
      dim_d_reg <= 1'b0;
    end else begin
      ce_d_reg  <= ce_eff;
      dim_d_reg <= dim_s;
    end
  end

  // Supply run window with hysteresis: starts above 4.5 V, stops below 3.5 V.
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      run_reg <= 1'b0;
    end else if (!vabove_s) begin
      run_reg <= 1'b0;
    end else if (vgood_s && ref_s) begin
      run_reg <= 1'b1;
    end
  end

  // Battery hysteresis for the high-side driver only.
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      hs_en_reg <= 1'b0;
    end else if (bathi_s) begin
      hs_en_reg <= 1'b1;
    end else if (!batlo_s) begin
      hs_en_reg <= 1'b0;
    end
  end

  // ****************************************************************
  // Sequencer
  // ****************************************************************
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      lamp_seq_pkg::ST_OFF: begin
        if (ce_eff && run_reg) state_next = lamp_seq_pkg::ST_START;
      end
      lamp_seq_pkg::ST_START: begin
        if (cur_s) begin
          state_next = lamp_seq_pkg::ST_FULL;
        end else if (blank_s) begin
          state_next = lamp_seq_pkg::ST_TIMEOUT;
        end
      end
      lamp_seq_pkg::ST_FULL: begin
        if (any_fault) begin
          state_next = lamp_seq_pkg::ST_FAULT;
        end else if (full_cnt_reg == 4'(FULL_CYCLES)) begin
          state_next = lamp_seq_pkg::ST_RUN;
        end
      end
      lamp_seq_pkg::ST_RUN: begin
        if (any_fault) state_next = lamp_seq_pkg::ST_FAULT;
      end
      lamp_seq_pkg::ST_FAULT:   state_next = lamp_seq_pkg::ST_FAULT;
      lamp_seq_pkg::ST_TIMEOUT: state_next = lamp_seq_pkg::ST_TIMEOUT;
      default:                  state_next = lamp_seq_pkg::ST_OFF;
    endcase
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= lamp_seq_pkg::ST_OFF;
    end else if (!ce_eff || ce_rise) begin
      state_reg <= lamp_seq_pkg::ST_OFF;
    end else begin
      state_reg <= state_next;
    end
  end

  // Counts full-brightness dimming cycles after the strike.
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      full_cnt_reg <= 4'h0;
    end else if (state_reg != lamp_seq_pkg::ST_FULL) begin
      full_cnt_reg <= 4'h0;
    end else if (dim_start && full_cnt_reg != 4'(FULL_CYCLES)) begin
      full_cnt_reg <= full_cnt_reg + 4'h1;
    end
  end

  // ****************************************************************
  // Fault detection and latch
  // ****************************************************************
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      uc_cnt_reg <= 8'h00;
    end else if (!steady || !blank_s || cur_s) begin
      uc_cnt_reg <= 8'h00;
    end else if (uc_cnt_reg != 8'(UC_CYCLES)) begin
      uc_cnt_reg <= uc_cnt_reg + 8'h01;
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      fault_reg <= 4'h0;
    end else begin
      // A fault that arrives together with a chip enable falling edge still latches.
      if (ce_fall || ce_rise) fault_reg <= 4'h0;
      if (steady && ovh_s) fault_reg[`FLT_HIGH_BIT] <= 1'b1;
      if (steady && blank_s && ovl_s) fault_reg[`FLT_LOW_BIT] <= 1'b1;
      if (steady && uc_cnt_reg == 8'(UC_CYCLES)) fault_reg[`FLT_UC_BIT] <= 1'b1;
      if (state_reg == lamp_seq_pkg::ST_TIMEOUT) fault_reg[`FLT_TIMEOUT_BIT] <= 1'b1;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  wire in_start = (state_reg == lamp_seq_pkg::ST_START);
  wire active   = (in_start || steady) && run_reg && !any_fault;

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      switching_enable          <= 1'b0;
      burst_gating              <= 1'b0;
      startup_phase             <= 1'b1;
      blanking_ramp_low_current <= 1'b1;
      aux_blanking_cap_switch   <= 1'b1;
      blanking_ramp_discharge   <= 1'b1;
      soft_start_ramp_source    <= 1'b0;
      soft_start_ramp_hold      <= 1'b1;
      fault_latched             <= 1'b0;
    end else begin
      switching_enable          <= active;
      burst_gating              <= (state_reg == lamp_seq_pkg::ST_RUN) && !dim_s;
      startup_phase             <= (state_reg == lamp_seq_pkg::ST_OFF) || in_start;
      blanking_ramp_low_current <= (state_reg == lamp_seq_pkg::ST_OFF) || in_start;
      aux_blanking_cap_switch   <= (state_reg == lamp_seq_pkg::ST_OFF) || in_start;
      blanking_ramp_discharge   <= !active || (steady && (dim_start ||
                                   ((state_reg == lamp_seq_pkg::ST_RUN) && !dim_s)));
      soft_start_ramp_source    <= active && !(in_start && ovh_s) &&
                                   ((state_reg != lamp_seq_pkg::ST_RUN) || (dim_s && !dim_end));
      soft_start_ramp_hold      <= !active || (in_start && ovh_s);
      fault_latched             <= any_fault;
    end
  end

  // Drive gating: high side stops at once on chip enable low, low sides run on the supply.
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      high_side_gate_drive <= 1'b0;
      low_side_drive_a     <= 1'b0;
      low_side_drive_b     <= 1'b0;
    end else begin
      high_side_gate_drive <= ce_eff && switching_enable && !burst_gating &&
                              hs_en_reg && high_side_pwm_in;
      low_side_drive_a     <= run_reg && !any_fault && (switching_enable || !ce_eff) &&
                              !burst_gating && drive_phase_in;
      low_side_drive_b     <= run_reg && !any_fault && (switching_enable || !ce_eff) &&
                              !burst_gating && !drive_phase_in;
    end
  end

  // Regulator base drive is released while chip enable is low.
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      regulator_base_drive_oe <= 1'b0;
    end else begin
      regulator_base_drive_oe <= ce_eff;
    end
  end
  assign regulator_base_drive_out = 1'b0;

  // ****************************************************************
  // Avalon-MM slave
  // ****************************************************************
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_reg <= `CTRL_RESET;
    end else if (avs_write && avs_address == `ADDR_CTRL) begin
      ctrl_reg <= {31'h0000_0000, avs_writedata[`CTRL_CE_BIT]};
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      avs_readdata <= 32'h0000_0000;
    end else if (avs_read && !rd_ack_reg) begin
      case (avs_address)
        `ADDR_CTRL:     avs_readdata <= ctrl_reg;
        `ADDR_STATUS:   avs_readdata <= {24'h00_0000, state_reg, hs_en_reg, run_reg,
                                         any_fault, startup_phase, switching_enable};
        `ADDR_FAULT:    avs_readdata <= {28'h000_0000, fault_reg};
        `ADDR_UC_LIMIT: avs_readdata <= {24'h00_0000, uc_cnt_reg};
        default:        avs_readdata <= 32'h0000_0000;
      endcase
    end
  end

  // A read stalls one cycle so that the registered data stand when waitrequest drops.
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      rd_ack_reg <= 1'b0;
    end else begin
      rd_ack_reg <= avs_read && !rd_ack_reg;
    end
  end

  assign avs_waitrequest = avs_read && !rd_ack_reg;

endmodule
`default_nettype wire

// *** lamp_seq_defs.svh ***
`ifndef LAMP_SEQ_DEFS_SVH
`define LAMP_SEQ_DEFS_SVH

// ****************************************************************
// Register map
// ****************************************************************
`define ADDR_CTRL          4'h0
`define ADDR_STATUS        4'h1
`define ADDR_FAULT         4'h2
`define ADDR_UC_LIMIT      4'h3

// ****************************************************************
// Field positions
// ****************************************************************
`define CTRL_CE_BIT        0
`define CTRL_FIRST_BIT     1
`define ST_SW_EN_BIT       0
`define ST_FIRST_BIT       1
`define ST_FAULT_BIT       2
`define ST_SHUT_BIT        3
`define ST_HS_EN_BIT       4
`define ST_STATE_LSB       5
`define FLT_HIGH_BIT       0
`define FLT_LOW_BIT        1
`define FLT_UC_BIT         2
`define FLT_TIMEOUT_BIT    3

// ****************************************************************
// Reset values and counts
// ****************************************************************
`define CTRL_RESET         32'h0000_0001
`define UC_CYCLES          8
`define FULL_BRIGHT_CYCLES 2

`endif

// *** lamp_seq_pkg.sv ***
`default_nettype none
package lamp_seq_pkg;

  typedef enum logic [2:0] {
    ST_OFF     = 3'b000,
    ST_START   = 3'b001,
    ST_FULL    = 3'b010,
    ST_RUN     = 3'b011,
    ST_FAULT   = 3'b100,
    ST_TIMEOUT = 3'b101
  } seq_state_t;

endpackage
`default_nettype wire

// *** lamp_seq_sva.sv ***
`timescale 1ns/100ps
`default_nettype none
// ****************************************************************
// Checks on the sequencer ports
// ****************************************************************
module lamp_seq_sva #(
  parameter int UC_CYCLES   = 8,
  parameter int FULL_CYCLES = 2
) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic chip_enable_in,
  input wire logic supply_above_off_in,
  input wire logic lamp_overvoltage_high_in,
  input wire logic lamp_current_detect_in,
  input wire logic battery_sense_in,
  input wire logic switching_enable,
  input wire logic startup_phase,
  input wire logic blanking_ramp_low_current,
  input wire logic aux_blanking_cap_switch,
  input wire logic soft_start_ramp_hold,
  input wire logic high_side_gate_drive,
  input wire logic low_side_drive_a,
  input wire logic low_side_drive_b,
  input wire logic regulator_base_drive_oe,
  input wire logic fault_latched
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  property p_ce_hs; !chip_enable_in [*5] |-> !high_side_gate_drive; endproperty
  a_ce_hs: assert property (p_ce_hs) else $error("high side on, enable low");
  property p_ce_reg; !chip_enable_in [*5] |-> !regulator_base_drive_oe; endproperty
  a_ce_reg: assert property (p_ce_reg) else $error("base drive on, enable low");
  property p_off; !supply_above_off_in [*5] |-> !switching_enable; endproperty
  a_off: assert property (p_off) else $error("switching below off level");
  property p_flt_sw; fault_latched [*3] |-> !switching_enable; endproperty
  a_flt_sw: assert property (p_flt_sw) else $error("switching with fault");
  property p_no_sf; $rose(fault_latched) |-> !$past(startup_phase); endproperty
  a_no_sf: assert property (p_no_sf) else $error("fault in start-up");
  property p_strike;
    switching_enable && startup_phase && lamp_current_detect_in |-> ##[1:6] !startup_phase;
  endproperty
  a_strike: assert property (p_strike) else $error("strike not seen");
  property p_first; startup_phase [*3] |-> blanking_ramp_low_current && aux_blanking_cap_switch;
  endproperty
  a_first: assert property (p_first) else $error("start-up ramp setup wrong");
  property p_later;
    !startup_phase [*3] |-> !blanking_ramp_low_current && !aux_blanking_cap_switch;
  endproperty
  a_later: assert property (p_later) else $error("steady ramp setup wrong");
  property p_hold; (startup_phase && lamp_overvoltage_high_in) [*5] |-> soft_start_ramp_hold;
  endproperty
  a_hold: assert property (p_hold) else $error("soft ramp not held");
  property p_batt; !battery_sense_in [*5] |-> !high_side_gate_drive; endproperty
  a_batt: assert property (p_batt) else $error("high side on, battery low");
  property p_latch; (fault_latched && chip_enable_in) [*6] |=> fault_latched; endproperty
  a_latch: assert property (p_latch) else $error("fault cleared early");
  property p_ovh;
    !startup_phase && switching_enable && lamp_overvoltage_high_in |-> ##[0:6] fault_latched;
  endproperty
  a_ovh: assert property (p_ovh) else $error("high overvoltage missed");
  property p_sw;
    (!switching_enable && !supply_above_off_in) [*5] |-> !low_side_drive_a && !low_side_drive_b;
  endproperty
  a_sw: assert property (p_sw) else $error("drives with enable low");
  c_fault: cover property (fault_latched);
  c_strike: cover property ($fell(startup_phase));
  c_decay: cover property (!chip_enable_in && low_side_drive_a);
endmodule

bind lamp_fault_startup_sequencer lamp_seq_sva #(
  .UC_CYCLES(UC_CYCLES), .FULL_CYCLES(FULL_CYCLES)) u_sva (.*);
`default_nettype wire

// *** lamp_fault_startup_sequencer_bench.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "lamp_seq_defs.svh"
module lamp_fault_startup_sequencer_bench;
  logic        core_clk = 1'h0;
  logic        reset_n = 1'h0;
  logic        chip_enable_in = 1'h1;
  logic        supply_good = 1'h0;
  logic        supply_above_off_in = 1'h0;
  logic        reference_valid_in = 1'h1;
  logic        lamp_overvoltage_high_in = 1'h0;
  logic        lamp_overvoltage_low_in = 1'h0;
  logic        lamp_current_detect_in = 1'h0;
  logic        blanking_ramp_above_in = 1'h0;
  logic        battery_sense_in = 1'h1;
  logic        battery_sense_high_in = 1'h1;
  logic        dimming_on_in = 1'h1;
  logic        drive_phase_in = 1'h0;
  logic        high_side_pwm_in = 1'h1;
  logic [3:0]  avs_address = 4'h0;
  logic        avs_read = 1'h0;
  logic        avs_write = 1'h0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest, switching_enable, burst_gating, startup_phase;
  logic        blanking_ramp_discharge, blanking_ramp_low_current, aux_blanking_cap_switch;
  logic        soft_start_ramp_source, soft_start_ramp_hold, high_side_gate_drive;
  logic        low_side_drive_a, low_side_drive_b, regulator_base_drive_out;
  logic        regulator_base_drive_oe, fault_latched;
  int          error_cnt = 0;
  int          cmp_count = 0;

  lamp_fault_startup_sequencer #(.UC_CYCLES(`UC_CYCLES), .FULL_CYCLES(`FULL_BRIGHT_CYCLES)) dut (.*);

  always #2.5 core_clk = ~core_clk;
  always @(posedge core_clk) drive_phase_in <= ~drive_phase_in;

  // ****************************************************************
  // Access and compare tasks
  // ****************************************************************
  task automatic step(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  task automatic chk(input string nm, input logic exp, input logic got);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %b seen %b", nm, exp, got);
    end
  endtask
  task automatic chkw(input string nm, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // The request is held until waitrequest is seen low; read data are taken at that edge.
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= ~wr;
    avs_write <= wr;
    do @(posedge core_clk); while (avs_waitrequest !== 1'h0);
    q = avs_readdata;
    avs_read <= 1'h0;
    avs_write <= 1'h0;
    @(posedge core_clk);
  endtask
  task automatic sides(output logic seen);
    seen = 1'h0;
    repeat (8) begin
      @(posedge core_clk);
      seen = seen | low_side_drive_a | low_side_drive_b;
    end
  endtask
  task automatic results();
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  initial begin
    step(5000);
    error_cnt++;
    results();
  end

  // ****************************************************************
  // Test sequence
  // ****************************************************************
  initial begin
    logic [31:0] q;
    logic        s;
    step(6);
    reset_n <= 1'h1;
    step(2);
    chk("startup_phase", 1'h1, startup_phase);
    chk("aux_switch", 1'h1, aux_blanking_cap_switch);
    bus(1'h0, `ADDR_CTRL, 32'h0, q);
    chkw("ctrl", `CTRL_RESET, q);
    bus(1'h0, 4'hF, 32'h0, q);
    chkw("unmapped", 32'h0, q);
    step(8);
    chk("sw_en", 1'h0, switching_enable);
    supply_good <= 1'h1;
    supply_above_off_in <= 1'h1;
    reference_valid_in <= 1'h0;
    step(10);
    chk("sw_en", 1'h0, switching_enable);
    reference_valid_in <= 1'h1;
    step(10);
    chk("sw_en", 1'h1, switching_enable);
    bus(1'h1, `ADDR_CTRL, 32'h0, q);
    step(6);
    chk("sw_en", 1'h0, switching_enable);
    bus(1'h1, `ADDR_CTRL, 32'h1, q);
    supply_good <= 1'h0;
    step(10);
    chk("sw_en", 1'h1, switching_enable);
    supply_above_off_in <= 1'h0;
    step(10);
    chk("sw_en", 1'h0, switching_enable);
    supply_good <= 1'h1;
    supply_above_off_in <= 1'h1;
    lamp_overvoltage_high_in <= 1'h1;
    lamp_overvoltage_low_in <= 1'h1;
    battery_sense_in <= 1'h0;
    battery_sense_high_in <= 1'h0;
    step(30);
    chk("fault", 1'h0, fault_latched);
    chk("ramp_hold", 1'h1, soft_start_ramp_hold);
    chk("high_side", 1'h0, high_side_gate_drive);
    sides(s);
    chk("low_sides", 1'h1, s);
    battery_sense_in <= 1'h1;
    battery_sense_high_in <= 1'h1;
    lamp_overvoltage_high_in <= 1'h0;
    lamp_overvoltage_low_in <= 1'h0;
    lamp_current_detect_in <= 1'h1;
    step(8);
    chk("startup_phase", 1'h0, startup_phase);
    chk("low_current", 1'h0, blanking_ramp_low_current);
    for (int i = 0; i < 5; i++) begin
      dimming_on_in <= 1'h0;
      step(20);
      if (i == 0)
        chk("burst_full", 1'h0, burst_gating);
      if (i == 4)
        chk("burst", 1'h1, burst_gating);
      if (i == 4)
        chk("ss_source", 1'h0, soft_start_ramp_source);
      dimming_on_in <= 1'h1;
      step(20);
    end
    chk("ss_source", 1'h1, soft_start_ramp_source);
    chk("discharge", 1'h0, blanking_ramp_discharge);
    lamp_current_detect_in <= 1'h0;
    lamp_overvoltage_low_in <= 1'h1;
    step(30);
    chk("fault", 1'h0, fault_latched);
    lamp_overvoltage_low_in <= 1'h0;
    blanking_ramp_above_in <= 1'h1;
    repeat (6) begin
      lamp_current_detect_in <= 1'h1;
      step(3);
      lamp_current_detect_in <= 1'h0;
      step(3);
    end
    step(1);
    chk("fault", 1'h0, fault_latched);
    step(14);
    chk("fault", 1'h1, fault_latched);
    chk("sw_en", 1'h0, switching_enable);
    bus(1'h0, `ADDR_FAULT, 32'h0, q);
    chk("uc_flag", 1'h1, q[`FLT_UC_BIT]);
    step(20);
    chk("fault", 1'h1, fault_latched);
    chip_enable_in <= 1'h0;
    blanking_ramp_above_in <= 1'h0;
    step(8);
    chk("high_side", 1'h0, high_side_gate_drive);
    chk("base_oe", 1'h0, regulator_base_drive_oe);
    chip_enable_in <= 1'h1;
    step(10);
    chk("fault", 1'h0, fault_latched);
    chk("aux_switch", 1'h1, aux_blanking_cap_switch);
    lamp_current_detect_in <= 1'h1;
    step(8);
    lamp_overvoltage_high_in <= 1'h1;
    step(10);
    chk("fault", 1'h1, fault_latched);
    bus(1'h0, `ADDR_FAULT, 32'h0, q);
    chk("ovh_flag", 1'h1, q[`FLT_HIGH_BIT]);
    lamp_overvoltage_high_in <= 1'h0;
    chip_enable_in <= 1'h0;
    step(5);
    chip_enable_in <= 1'h1;
    step(10);
    blanking_ramp_above_in <= 1'h1;
    lamp_overvoltage_low_in <= 1'h1;
    step(10);
    chk("fault", 1'h1, fault_latched);
    bus(1'h0, `ADDR_FAULT, 32'h0, q);
    chk("ovl_flag", 1'h1, q[`FLT_LOW_BIT]);
    chip_enable_in <= 1'h0;
    lamp_current_detect_in <= 1'h0;
    lamp_overvoltage_low_in <= 1'h0;
    blanking_ramp_above_in <= 1'h0;
    step(8);
    chk("base_out", 1'h0, regulator_base_drive_out);
    chip_enable_in <= 1'h1;
    step(10);
    chk("sw_en", 1'h1, switching_enable);
    chk("base_oe", 1'h1, regulator_base_drive_oe);
    blanking_ramp_above_in <= 1'h1;
    step(8);
    chk("sw_en", 1'h0, switching_enable);
    bus(1'h0, `ADDR_FAULT, 32'h0, q);
    chk("timeout_flag", 1'h1, q[`FLT_TIMEOUT_BIT]);
    bus(1'h0, `ADDR_STATUS, 32'h0, q);
    chkw("status", 32'h0000_00B8, q);
    results();
  end
endmodule
`default_nettype wire
